// File: src/spp_regs.svh
// constants for the single-pin port: register offsets, fields, reset values
// assumes the special-function bus presents byte addresses and an 8-bit data path
// Summary of operation
// - The pin mode comes from the mode bit of mode-select A paired with the bit of mode-select B.
// - Mode bits A,B encode 00 quasi-bidirectional, 01 push-pull, 10 input-only, 11 open-drain.
// - The input-type bit picks a TTL input when clear and a Schmitt input when set.
// - The slew bit gives normal slew when clear and high-speed slew when set.
// - Mode-select A and B sit on page 0, input-type and slew on page 1, sharing addresses.
// - Mode-select A resets to 0x01 and the other three configuration registers to 0x00.
// - Bits 7 to 1 of the port data register always read as zero.
// - The pin works as general purpose I/O only while the internal oscillator clocks the system.
// - Otherwise the pin is the external clock input, data writes are ignored and the bit reads 0.
// - The port data register resets to 0x01 with the output latch high.
`ifndef SPP_REGS_SVH
`define SPP_REGS_SVH
`define SPP_ADDR_MODE_A   8'hAC
`define SPP_ADDR_INTYPE   8'hAC
`define SPP_ADDR_MODE_B   8'hAD
`define SPP_ADDR_SLEW     8'hAD
`define SPP_ADDR_DATA     8'hB0
`define SPP_BIT_PIN       0
`define SPP_RST_MODE_A    1'b1
`define SPP_RST_MODE_B    1'b0
`define SPP_RST_INTYPE    1'b0
`define SPP_RST_SLEW      1'b0
`define SPP_RST_LATCH     1'b1
`endif

// File: src/spp_pkg.sv
// types for the single-pin port
// assumes nothing of its surroundings
package spp_pkg;
  typedef enum logic [1:0] {
    SPP_QUASI,
    SPP_PUSH_PULL,
    SPP_INPUT_ONLY,
    SPP_OPEN_DRAIN
  } spp_mode_e;
endpackage : spp_pkg

// File: src/spp_pad_ctrl.sv
// pad driver control for the single pin
// assumes the pad applies the drive request combinationally
`timescale 1ns/1ps
`default_nettype none
module spp_pad_ctrl (
  // configuration
  input  wire logic              mode_a,
  input  wire logic              mode_b,
  input  wire logic              gpio_ok,
  input  wire logic              latch,
  // pad request
  output logic                   drive_out,
  output logic                   drive_oe_n
);
  spp_pkg::spp_mode_e mode;
  assign mode = spp_pkg::spp_mode_e'({mode_a, mode_b});
  always_comb begin
    drive_out  = latch;
    drive_oe_n = 1'b1;
    if (gpio_ok) begin
      case (mode)
        spp_pkg::SPP_PUSH_PULL:  drive_oe_n = 1'b0;
        spp_pkg::SPP_INPUT_ONLY: drive_oe_n = 1'b1;
        spp_pkg::SPP_OPEN_DRAIN: drive_oe_n = latch;
        spp_pkg::SPP_QUASI:      drive_oe_n = latch;
        default:                 drive_oe_n = 1'b1;
      endcase
    end
  end
endmodule : spp_pad_ctrl
`default_nettype wire

// File: src/spp_port.sv
// single-pin port with its special-function registers and pad control
// assumes a synchronous byte bus with one-cycle write and read strobes
`timescale 1ns/1ps
`default_nettype none
`include "spp_regs.svh"
module spp_port (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // register bus
  input  wire logic [7:0]        sfr_addr,
  input  wire logic [7:0]        sfr_wdata,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire logic              sfr_page,
  output logic      [7:0]        sfr_rdata,
  output logic                   sfr_rvalid,
  // clock source
  input  wire logic              int_osc_sel,
  // pin
  input  wire logic              pin_in,
  output logic                   pin_out,
  output logic                   pin_oe_n,
  output logic                   pin_schmitt,
  output logic                   pin_fast_slew,
  output logic                   ext_clock_input
);
  logic mode_a;
  logic mode_b;
  logic latch;
  logic pin_sample;
  logic pad_out;
  logic pad_oe_n;
  logic hit_a;
  logic hit_b;
  logic hit_d;

  assign hit_a = (sfr_addr == `SPP_ADDR_MODE_A);
  assign hit_b = (sfr_addr == `SPP_ADDR_MODE_B);
  assign hit_d = (sfr_addr == `SPP_ADDR_DATA);

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_a        <= `SPP_RST_MODE_A;
      mode_b        <= `SPP_RST_MODE_B;
      pin_schmitt   <= `SPP_RST_INTYPE;
      pin_fast_slew <= `SPP_RST_SLEW;
    end else if (sfr_wr) begin
      if (hit_a && !sfr_page) mode_a <= sfr_wdata[`SPP_BIT_PIN];
      if (hit_b && !sfr_page) mode_b <= sfr_wdata[`SPP_BIT_PIN];
      if (hit_a && sfr_page) pin_schmitt <= sfr_wdata[`SPP_BIT_PIN];
      if (hit_b && sfr_page) pin_fast_slew <= sfr_wdata[`SPP_BIT_PIN];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      latch <= `SPP_RST_LATCH;
    end else if (sfr_wr && hit_d && int_osc_sel) begin
      latch <= sfr_wdata[`SPP_BIT_PIN];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) pin_sample <= 1'b0;
    else       pin_sample <= pin_in;
  end

  spp_pad_ctrl u_pad (
    .mode_a     (mode_a),
    .mode_b     (mode_b),
    .gpio_ok    (int_osc_sel),
    .latch      (latch),
    .drive_out  (pad_out),
    .drive_oe_n (pad_oe_n)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_out         <= `SPP_RST_LATCH;
      pin_oe_n        <= 1'b1;
      ext_clock_input <= 1'b0;
    end else begin
      pin_out         <= pad_out;
      pin_oe_n        <= pad_oe_n;
      ext_clock_input <= !int_osc_sel && pin_in;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sfr_rdata  <= 8'h00;
      sfr_rvalid <= 1'b0;
    end else begin
      sfr_rvalid <= sfr_rd;
      sfr_rdata  <= 8'h00;
      if (sfr_rd) begin
        if (hit_a) sfr_rdata <= {7'h00, sfr_page ? pin_schmitt : mode_a};
        if (hit_b) sfr_rdata <= {7'h00, sfr_page ? pin_fast_slew : mode_b};
        if (hit_d) sfr_rdata <= {7'h00, int_osc_sel & pin_sample};
      end
    end
  end

  a_data_zero_off: assert property (@(posedge clk) disable iff (reset)
    (sfr_rd && hit_d && !int_osc_sel) |=> sfr_rdata == 8'h00)
    else $error("data bit not zero off oscillator");
  a_upper_zero: assert property (@(posedge clk) disable iff (reset)
    sfr_rdata[7:1] == 7'h00)
    else $error("upper read bits nonzero");
  a_push_drive: assert property (@(posedge clk) disable iff (reset)
    (int_osc_sel && !mode_a && mode_b) |=> !pin_oe_n && pin_out == $past(latch))
    else $error("push-pull not driving latch");
  a_input_hiz: assert property (@(posedge clk) disable iff (reset)
    (mode_a && !mode_b) |=> pin_oe_n)
    else $error("input-only drives pin");
  a_off_osc_hiz: assert property (@(posedge clk) disable iff (reset)
    !int_osc_sel |=> pin_oe_n)
    else $error("pin driven off oscillator");
  a_write_blocked: assert property (@(posedge clk) disable iff (reset)
    (sfr_wr && hit_d && !int_osc_sel) |=> $stable(latch))
    else $error("data write taken off oscillator");
  a_page_one_keep: assert property (@(posedge clk) disable iff (reset)
    (sfr_wr && hit_a && sfr_page) |=> $stable(mode_a) && pin_schmitt == $past(sfr_wdata[0]))
    else $error("page select wrong");
  a_slew_write: assert property (@(posedge clk) disable iff (reset)
    (sfr_wr && hit_b && sfr_page) |=> pin_fast_slew == $past(sfr_wdata[0]) && $stable(mode_b))
    else $error("slew write wrong");
  a_read_pin: assert property (@(posedge clk) disable iff (reset)
    (sfr_rd && hit_d && int_osc_sel) |=> sfr_rdata[0] == $past(pin_sample))
    else $error("data read not pin level");
  a_reset_vals: assert property (@(posedge clk)
    $past(reset) |-> mode_a && !mode_b && !pin_schmitt && !pin_fast_slew && latch)
    else $error("reset values wrong");

  // data write steps: strobe, latch, pad
  sequence s_data_write;
    sfr_wr && hit_d && int_osc_sel;
  endsequence
  sequence s_pad_follows;
    ##1 pin_out == $past(sfr_wdata[`SPP_BIT_PIN], 2);
  endsequence

  a_write_to_pad: assert property (@(posedge clk) disable iff (reset)
    s_data_write |=> s_pad_follows)
    else $error("data write not on pad");

  a_latch_write: assert property (@(posedge clk) disable iff (reset)
    s_data_write |=> latch == $past(sfr_wdata[`SPP_BIT_PIN]))
    else $error("latch not written");

  a_open_drain: assert property (@(posedge clk) disable iff (reset)
    (int_osc_sel && mode_a && mode_b) |=> pin_oe_n == $past(latch))
    else $error("open-drain enable wrong");

  a_quasi_drive: assert property (@(posedge clk) disable iff (reset)
    (int_osc_sel && !mode_a && !mode_b) |=> pin_oe_n == $past(latch))
    else $error("quasi enable wrong");

  a_mode_a_write: assert property (@(posedge clk) disable iff (reset)
    (sfr_wr && hit_a && !sfr_page) |=> mode_a == $past(sfr_wdata[0]) && $stable(pin_schmitt))
    else $error("mode A write wrong");

  a_mode_b_write: assert property (@(posedge clk) disable iff (reset)
    (sfr_wr && hit_b && !sfr_page) |=> mode_b == $past(sfr_wdata[0]) && $stable(pin_fast_slew))
    else $error("mode B write wrong");

  a_mode_a_read: assert property (@(posedge clk) disable iff (reset)
    (sfr_rd && hit_a && !sfr_page) |=> sfr_rdata == {7'h00, $past(mode_a)})
    else $error("mode A read wrong");

  a_mode_b_read: assert property (@(posedge clk) disable iff (reset)
    (sfr_rd && hit_b && !sfr_page) |=> sfr_rdata == {7'h00, $past(mode_b)})
    else $error("mode B read wrong");

  a_intype_read: assert property (@(posedge clk) disable iff (reset)
    (sfr_rd && hit_a && sfr_page) |=> sfr_rdata == {7'h00, $past(pin_schmitt)})
    else $error("input type read wrong");

  a_slew_read: assert property (@(posedge clk) disable iff (reset)
    (sfr_rd && hit_b && sfr_page) |=> sfr_rdata == {7'h00, $past(pin_fast_slew)})
    else $error("slew read wrong");

  a_rvalid_pulse: assert property (@(posedge clk) disable iff (reset)
    sfr_rd |=> sfr_rvalid)
    else $error("read not answered");

  a_idle_zero: assert property (@(posedge clk) disable iff (reset)
    !sfr_rd |=> !sfr_rvalid && sfr_rdata == 8'h00)
    else $error("read data outside answer");

  a_ext_clock: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> ext_clock_input == $past(!int_osc_sel && pin_in))
    else $error("clock input wrong");

  a_no_ext_clock: assert property (@(posedge clk) disable iff (reset)
    int_osc_sel |=> !ext_clock_input)
    else $error("clock input while gpio");
endmodule : spp_port
`default_nettype wire

// File: tb/spp_pin_model.sv
// board model of the port pin: weak pull-up and an optional driver
// assumes the port drives the pad while pin_oe_n is low
`timescale 1ns/1ps
`default_nettype none
module spp_pin_model (
  // pad side
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  // board driver
  input  wire logic ext_en,
  input  wire logic ext_lv,
  // sensed level
  output logic      pin_in
);
  // port wins, then board driver, else pull-up
  assign pin_in = !pin_oe_n ? pin_out : (ext_en ? ext_lv : 1'b1);
endmodule : spp_pin_model
`default_nettype wire

// File: tb/tb_spp_port.sv
// self-checking bench for the single-pin port
// assumes a 40 MHz clock and the board model on the pin
`timescale 1ns/1ps
`default_nettype none
`include "spp_regs.svh"
module tb_spp_port;
  logic       clk, reset, wr, rd, page, osc, ext_en, ext_lv, e_oe;
  logic [7:0] addr, wdata;
  wire  [7:0] rdata;
  wire        rvalid, pin_in, pin_out, oe_n, schmitt, slew, xclk;
  int         n_mismatch = 0;
  int         checks = 0;
  spp_port DUT (.clk(clk), .reset(reset), .sfr_addr(addr), .sfr_wdata(wdata),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_page(page), .sfr_rdata(rdata), .sfr_rvalid(rvalid),
    .int_osc_sel(osc), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(oe_n),
    .pin_schmitt(schmitt), .pin_fast_slew(slew), .ext_clock_input(xclk));
  spp_pin_model pad (.pin_out(pin_out), .pin_oe_n(oe_n), .ext_en(ext_en),
    .ext_lv(ext_lv), .pin_in(pin_in));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one-cycle write strobe, entered at a falling edge
  task automatic wr_reg(input logic p, input logic [7:0] a, input logic [7:0] d);
    page = p;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : wr_reg
  // read answer stands the cycle after the strobe
  task automatic rd_reg(input logic p, input logic [7:0] a, input logic [7:0] exp);
    page = p;
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    check({7'b0, rvalid}, 8'h01);
    check(rdata, exp);
    @(negedge clk);
  endtask : rd_reg
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #50us;
    n_mismatch++;
    finish_test();
  end
  initial begin
    {wr, rd, page, ext_en, ext_lv, addr, wdata} = '0;
    osc = 1'b1;
    reset = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    rd_reg(1'b0, `SPP_ADDR_MODE_A, 8'h01);
    rd_reg(1'b1, `SPP_ADDR_INTYPE, 8'h00);
    rd_reg(1'b0, `SPP_ADDR_MODE_B, 8'h00);
    rd_reg(1'b1, `SPP_ADDR_SLEW, 8'h00);
    check({6'b0, oe_n, pin_out}, 8'h03);
    rd_reg(1'b0, `SPP_ADDR_DATA, 8'h01);
    for (int m = 0; m < 4; m++) begin
      for (int l = 0; l < 2; l++) begin
        wr_reg(1'b0, `SPP_ADDR_MODE_A, {7'h7f, m[1]});
        wr_reg(1'b0, `SPP_ADDR_MODE_B, {7'h7f, m[0]});
        wr_reg(1'b0, `SPP_ADDR_DATA, {7'h7f, l[0]});
        repeat (3) @(negedge clk);
        e_oe = (m == 1) ? 1'b0 : (m == 2) ? 1'b1 : l[0];
        check({6'b0, oe_n, pin_out | oe_n}, {6'b0, e_oe, l[0] | e_oe});
        rd_reg(1'b0, `SPP_ADDR_DATA, {7'b0, l[0] | e_oe});
      end
    end
    wr_reg(1'b1, `SPP_ADDR_INTYPE, 8'hff);
    wr_reg(1'b1, `SPP_ADDR_SLEW, 8'hff);
    check({6'b0, schmitt, slew}, 8'h03);
    rd_reg(1'b1, `SPP_ADDR_INTYPE, 8'h01);
    rd_reg(1'b0, `SPP_ADDR_MODE_A, 8'h01);
    rd_reg(1'b0, `SPP_ADDR_MODE_B, 8'h01);
    wr_reg(1'b1, `SPP_ADDR_SLEW, 8'h00);
    wr_reg(1'b1, `SPP_ADDR_INTYPE, 8'h00);
    check({6'b0, schmitt, slew}, 8'h00);
    rd_reg(1'b1, `SPP_ADDR_SLEW, 8'h00);
    wr_reg(1'b0, `SPP_ADDR_MODE_A, 8'h00);
    osc = 1'b0;
    wr_reg(1'b0, `SPP_ADDR_DATA, 8'h00);
    ext_en = 1'b1;
    for (int l = 0; l < 2; l++) begin
      ext_lv = l[0];
      repeat (3) @(negedge clk);
      check({6'b0, oe_n, xclk}, {6'b0, 1'b1, l[0]});
      rd_reg(1'b0, `SPP_ADDR_DATA, 8'h00);
    end
    ext_en = 1'b0;
    osc = 1'b1;
    repeat (3) @(negedge clk);
    check({6'b0, oe_n, xclk}, 8'h00);
    rd_reg(1'b0, `SPP_ADDR_DATA, 8'h01);
    rd_reg(1'b0, 8'hae, 8'h00);
    finish_test();
  end
endmodule : tb_spp_port
`default_nettype wire
